// >>> vpic_device.sv
/*
 Vectored priority interrupt controller, normal-interrupt path with
 priority stack, plus a minimal fast request. Assumes one free running
 sys_clk, synchronous active-low reset, sources synchronous to sys_clk.
*/
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "vpic_params.svh"

module vpic_device #(
  parameter int NUM_SRC = `VPIC_NUM_SRC,
  parameter int STACK_DEPTH = `VPIC_STACK_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Interrupt sources
  input wire logic [NUM_SRC-1:0] irq_source,
  // Link to the core
  vpic_link_if.device link
);

  if (NUM_SRC != 32 || STACK_DEPTH != 8)
  begin : g_chk
    $error("vpic_device supports 32 sources and an 8-deep stack only");
  end

  logic [2:0] prio_r [NUM_SRC], prio_nxt [NUM_SRC];
  logic [1:0] type_r [NUM_SRC], type_nxt [NUM_SRC];
  logic [31:0] svr_r [NUM_SRC], svr_nxt [NUM_SRC];
  logic [NUM_SRC-1:0] en_r, en_nxt;
  logic [NUM_SRC-1:0] ff_r, ff_nxt;
  logic [NUM_SRC-1:0] src_q_r, src_q_nxt;
  logic [NUM_SRC-1:0] edge_r, edge_nxt;
  vpic_pkg::vpic_src_type stk_src_r [STACK_DEPTH], stk_src_nxt [STACK_DEPTH];
  vpic_pkg::vpic_lvl_type stk_lvl_r [STACK_DEPTH], stk_lvl_nxt [STACK_DEPTH];
  logic [3:0] sp_r, sp_nxt;
  logic irq_n_r, irq_n_nxt, fiq_n_r, fiq_n_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic [NUM_SRC-1:0] act, det, pend, elig;
  logic best_valid, cur_valid, outranks;
  vpic_pkg::vpic_src_type best_src, cur_src;
  vpic_pkg::vpic_lvl_type best_lvl, cur_lvl;
  logic ivr_rd, fvr_rd, eoi_wr, take;
  logic [4:0] idx;

  assign idx = link.bus_addr[6:2];
  assign ivr_rd = link.bus_rd && (link.bus_addr == `VPIC_IVR_ADDR);
  assign fvr_rd = link.bus_rd && (link.bus_addr == `VPIC_FVR_ADDR);
  assign eoi_wr = link.bus_wr && (link.bus_addr == `VPIC_EOI_ADDR);
  assign cur_valid = (sp_r != 4'h0);
  assign cur_src = cur_valid ? stk_src_r[sp_r[2:0] - 3'h1] : 5'h00;
  assign cur_lvl = cur_valid ? stk_lvl_r[sp_r[2:0] - 3'h1] : 3'h0;

  // Source conditioning per trigger type
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      act[i] = type_r[i][`VPIC_TYPE_POS_BIT] ? irq_source[i] : ~irq_source[i];
      det[i] = act[i] & ~(type_r[i][`VPIC_TYPE_POS_BIT] ? src_q_r[i] : ~src_q_r[i]);
      pend[i] = type_r[i][`VPIC_TYPE_EDGE_BIT] ? edge_r[i] : act[i];
    end
    elig = pend & en_r & ~ff_r;
  end

  // Priority arbitration
  always_comb
  begin
    best_valid = 1'b0;
    best_src = 5'h00;
    best_lvl = 3'h0;
    // Source 0 left out of the scan
    for (int i = NUM_SRC - 1; i >= 1; i--)
    begin
      if (elig[i] && (!best_valid || prio_r[i] >= best_lvl))
      begin
        best_valid = 1'b1;
        best_src = 5'(i);
        best_lvl = prio_r[i];
      end
    end
    outranks = best_valid && (!cur_valid || best_lvl > cur_lvl);
  end

  // Selection sampled at the vector read
  assign take = ivr_rd && outranks;

  always_comb
  begin
    prio_nxt = prio_r;
    type_nxt = type_r;
    svr_nxt = svr_r;
    en_nxt = en_r;
    ff_nxt = ff_r;
    stk_src_nxt = stk_src_r;
    stk_lvl_nxt = stk_lvl_r;
    sp_nxt = sp_r;
    src_q_nxt = irq_source;
    edge_nxt = edge_r;
    rdata_nxt = 32'h00000000;
    if (link.bus_wr)
    begin
      if ((link.bus_addr & ~`VPIC_IDX_MASK) == `VPIC_SMR_BASE)
      begin
        prio_nxt[idx] = link.bus_wdata[`VPIC_PRIO_LSB +: 3];
        type_nxt[idx] = link.bus_wdata[`VPIC_TYPE_LSB +: 2];
      end
      else if ((link.bus_addr & ~`VPIC_IDX_MASK) == `VPIC_SVR_BASE)
      begin
        svr_nxt[idx] = link.bus_wdata;
      end
      else if (link.bus_addr == `VPIC_IEN_ADDR)
      begin
        en_nxt = link.bus_wdata[NUM_SRC-1:0];
      end
      else if (link.bus_addr == `VPIC_FFR_ADDR)
      begin
        ff_nxt = {link.bus_wdata[NUM_SRC-1:1], 1'b0};
      end
    end
    if (link.bus_rd)
    begin
      if ((link.bus_addr & ~`VPIC_IDX_MASK) == `VPIC_SMR_BASE)
      begin
        rdata_nxt[`VPIC_PRIO_LSB +: 3] = prio_r[idx];
        rdata_nxt[`VPIC_TYPE_LSB +: 2] = type_r[idx];
      end
      else if ((link.bus_addr & ~`VPIC_IDX_MASK) == `VPIC_SVR_BASE)
      begin
        rdata_nxt = svr_r[idx];
      end
      else if (ivr_rd)
      begin
        rdata_nxt = take ? svr_r[best_src] : `VPIC_SPURIOUS_VEC;
      end
      else if (fvr_rd)
      begin
        rdata_nxt = svr_r[0];
      end
      else if (link.bus_addr == `VPIC_CUR_ADDR)
      begin
        rdata_nxt = {20'h00000, sp_r, cur_lvl, cur_src};
      end
      else if (link.bus_addr == `VPIC_PEND_ADDR)
      begin
        rdata_nxt = pend;
      end
      else if (link.bus_addr == `VPIC_IEN_ADDR)
      begin
        rdata_nxt = en_r;
      end
      else if (link.bus_addr == `VPIC_FFR_ADDR)
      begin
        rdata_nxt = ff_r;
      end
    end

    // Pop before push; both never occur in one cycle on this bus
    if (eoi_wr && cur_valid)
    begin
      sp_nxt = sp_r - 4'h1;
    end
    // Full stack refuses a further push
    else if (take && sp_r < 4'(STACK_DEPTH))
    begin
      stk_src_nxt[sp_r[2:0]] = best_src;
      stk_lvl_nxt[sp_r[2:0]] = best_lvl;
      sp_nxt = sp_r + 4'h1;
    end

    for (int i = 0; i < NUM_SRC; i++)
    begin
      // Forced sources are never eligible here
      if ((take && i == int'(best_src)) || (fvr_rd && i == 0))
      begin
        edge_nxt[i] = 1'b0;
      end
      // New edge wins over a same-cycle clear
      if (type_r[i][`VPIC_TYPE_EDGE_BIT] && det[i])
      begin
        edge_nxt[i] = 1'b1;
      end
    end

    irq_n_nxt = ~outranks | ivr_rd;
    // Fast request from source 0 or forced ones
    fiq_n_nxt = ~((pend[0] & en_r[0]) | (|(pend & en_r & ff_r)));
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sp_r <= 4'h0;
      irq_n_r <= 1'b1;
      fiq_n_r <= 1'b1;
      rdata_r <= 32'h00000000;
      en_r <= `VPIC_MASK_RST;
      ff_r <= `VPIC_MASK_RST;
      src_q_r <= '0;
      edge_r <= '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
        prio_r[i] <= `VPIC_PRIO_RST;
        type_r[i] <= `VPIC_TYPE_RST;
        svr_r[i] <= `VPIC_SVR_RST;
      end
      for (int j = 0; j < STACK_DEPTH; j++)
      begin
        stk_src_r[j] <= 5'h00;
        stk_lvl_r[j] <= 3'h0;
      end
    end
    else
    begin
      sp_r <= sp_nxt;
      irq_n_r <= irq_n_nxt;
      fiq_n_r <= fiq_n_nxt;
      rdata_r <= rdata_nxt;
      en_r <= en_nxt;
      ff_r <= ff_nxt;
      src_q_r <= src_q_nxt;
      edge_r <= edge_nxt;
      prio_r <= prio_nxt;
      type_r <= type_nxt;
      svr_r <= svr_nxt;
      stk_src_r <= stk_src_nxt;
      stk_lvl_r <= stk_lvl_nxt;
    end
  end

  assign link.bus_rdata = rdata_r;
  assign link.normal_irq_request_n = irq_n_r;
  assign link.fast_irq_request_n = fiq_n_r;

endmodule : vpic_device

// >>> vpic_params.svh
/*
 Register map, field positions, reset values and trigger encodings
 of the vectored priority interrupt controller. Definitions only.
*/
`ifndef VPIC_PARAMS_SVH
`define VPIC_PARAMS_SVH

`define VPIC_SMR_BASE 32'hfffff000
`define VPIC_SVR_BASE 32'hfffff080
`define VPIC_IDX_MASK 32'h0000007c
`define VPIC_IVR_ADDR 32'hfffff100
`define VPIC_FVR_ADDR 32'hfffff104
`define VPIC_CUR_ADDR 32'hfffff108
`define VPIC_PEND_ADDR 32'hfffff10c
`define VPIC_IEN_ADDR 32'hfffff110
`define VPIC_FFR_ADDR 32'hfffff114
`define VPIC_EOI_ADDR 32'hfffff130

`define VPIC_PRIO_LSB 0
`define VPIC_TYPE_LSB 5
`define VPIC_TYPE_EDGE_BIT 1
`define VPIC_TYPE_POS_BIT 0

`define VPIC_PRIO_RST 3'h0
`define VPIC_TYPE_RST 2'h0
`define VPIC_SVR_RST 32'h00000000
`define VPIC_MASK_RST 32'h00000000
`define VPIC_SPURIOUS_VEC 32'h00000000
`define VPIC_STACK_DEPTH 8
`define VPIC_NUM_SRC 32

`endif

// >>> vpic_pkg.sv
/*
 Types shared by both ends of the interrupt controller link.
 Assumes vpic_params.svh for numeric constants.
*/
package vpic_pkg;

  typedef logic [4:0] vpic_src_type;
  typedef logic [2:0] vpic_lvl_type;

  typedef enum logic [1:0] {
    VPIC_H_IDLE,
    VPIC_H_VEC,
    VPIC_H_SERVE,
    VPIC_H_EOI
  } vpic_host_state_type;

endpackage : vpic_pkg

// >>> vpic_link_if.sv
/*
 Link between the interrupt controller and the processor core:
 register bus driven by the core, read data and request lines driven by the controller.
 Assumes both ends run on the same sys_clk.
*/
`timescale 1ns/100ps

interface vpic_link_if;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic normal_irq_request_n;
  logic fast_irq_request_n;

  modport device (
    input bus_addr,
    input bus_wdata,
    input bus_wr,
    input bus_rd,
    output bus_rdata,
    output normal_irq_request_n,
    output fast_irq_request_n
  );

  modport core (
    output bus_addr,
    output bus_wdata,
    output bus_wr,
    output bus_rd,
    input bus_rdata,
    input normal_irq_request_n,
    input fast_irq_request_n
  );
endinterface : vpic_link_if

// >>> vpic_core_end.sv
/*
 Processor-core end of the link: takes the normal request, reads the
 vector, hands it to the user, then writes end-of-service. Also passes
 plain register accesses through while idle. Assumes sys_clk shared.
*/
`timescale 1ns/100ps
`include "vpic_params.svh"

module vpic_core_end (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register access port
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [31:0] cpu_rdata,
  output logic cpu_ready,
  // Interrupt service port
  input wire logic irq_unmask,
  output logic [31:0] handler_addr,
  output logic handler_valid,
  input wire logic handler_done,
  output logic fast_pending,
  // Link to the controller
  vpic_link_if.core link
);

  vpic_pkg::vpic_host_state_type state_r, state_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic [31:0] haddr_r, haddr_nxt;
  logic hval_r, hval_nxt;
  logic enter;

  // Masked automatically while any service is open
  assign enter = (state_r == vpic_pkg::VPIC_H_IDLE) && irq_unmask && !link.normal_irq_request_n;
  assign cpu_ready = (state_r == vpic_pkg::VPIC_H_IDLE) && !enter;

  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    haddr_nxt = haddr_r;
    hval_nxt = 1'b0;
    case (state_r)
      vpic_pkg::VPIC_H_IDLE:
      begin
        if (enter)
        begin
          // Vector read to drop the request
          rd_nxt = 1'b1;
          addr_nxt = `VPIC_IVR_ADDR;
          state_nxt = vpic_pkg::VPIC_H_VEC;
        end
        else if (cpu_wr || cpu_rd)
        begin
          wr_nxt = cpu_wr;
          rd_nxt = cpu_rd & ~cpu_wr;
          addr_nxt = cpu_addr;
          wdata_nxt = cpu_wdata;
        end
      end
      vpic_pkg::VPIC_H_VEC:
      begin
        // Read data stand only in the cycle after the strobe
        if (!rd_r)
        begin
          state_nxt = vpic_pkg::VPIC_H_SERVE;
        end
      end
      vpic_pkg::VPIC_H_SERVE:
      begin
        if (handler_done)
        begin
          wr_nxt = 1'b1;
          addr_nxt = `VPIC_EOI_ADDR;
          wdata_nxt = 32'h00000000;
          state_nxt = vpic_pkg::VPIC_H_EOI;
        end
      end
      vpic_pkg::VPIC_H_EOI:
      begin
        state_nxt = vpic_pkg::VPIC_H_IDLE;
      end
      default:
      begin
        state_nxt = vpic_pkg::VPIC_H_IDLE;
      end
    endcase
    if (state_r == vpic_pkg::VPIC_H_VEC && !rd_r)
    begin
      haddr_nxt = link.bus_rdata;
      hval_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_r <= vpic_pkg::VPIC_H_IDLE;
      addr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      haddr_r <= 32'h00000000;
      hval_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      haddr_r <= haddr_nxt;
      hval_r <= hval_nxt;
    end
  end

  assign link.bus_addr = addr_r;
  assign link.bus_wdata = wdata_r;
  assign link.bus_wr = wr_r;
  assign link.bus_rd = rd_r;
  assign cpu_rdata = link.bus_rdata;
  assign handler_addr = haddr_r;
  assign handler_valid = hval_r;
  assign fast_pending = ~link.fast_irq_request_n;

endmodule : vpic_core_end

// >>> vpic_link_monitor.sv
/*
 Concurrent checks on the link between controller and core end.
 Assumes one sys_clk and a synchronous active-low reset_n.
*/
`timescale 1ns/100ps
`include "vpic_params.svh"

module vpic_link_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link signals
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic normal_irq_request_n,
  input wire logic fast_irq_request_n
);
  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence ivr_rd_s;
    bus_rd && bus_addr == `VPIC_IVR_ADDR;
  endsequence
  sequence eoi_wr_s;
    bus_wr && bus_addr == `VPIC_EOI_ADDR;
  endsequence

  ivr_drop_req_a: assert property (ivr_rd_s |=> normal_irq_request_n)
    else $error("request low after vector read");
  eoi_hold_a: assert property (eoi_wr_s ##0 normal_irq_request_n |=> normal_irq_request_n)
    else $error("request fell right after end of service");
  eoi_quiet_a: assert property (eoi_wr_s |=> bus_rdata == 32'h00000000)
    else $error("read data after end of service write");
  // Reset checks must run while reset is low
  reset_idle_a: assert property (disable iff (1'b0) !reset_n |=> normal_irq_request_n && fast_irq_request_n)
    else $error("request active after reset");
  reset_rdata_a: assert property (disable iff (1'b0) !reset_n |=> bus_rdata == 32'h00000000)
    else $error("read data not zero after reset");
  rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 32'h00000000)
    else $error("read data without read");
  strobe_excl_a: assert property (!(bus_rd && bus_wr))
    else $error("read and write strobes together");
  req_fall_live_a: assert property ($fell(normal_irq_request_n) |-> $past(reset_n, 2))
    else $error("request fell too soon after reset");
endmodule : vpic_link_monitor

// >>> tb_vectored_priority_irq_controller.sv
/*
 Self-checking bench: controller and core end joined by the link.
 Assumes vpic_params.svh register map; sources idle high (reset type).
*/
`timescale 1ns/100ps
`include "vpic_params.svh"

module tb_vectored_priority_irq_controller;
  localparam logic [31:0] IVR = `VPIC_IVR_ADDR;
  localparam logic [31:0] CUR = `VPIC_CUR_ADDR;
  localparam logic [31:0] PEND = `VPIC_PEND_ADDR;
  localparam logic [31:0] IEN = `VPIC_IEN_ADDR;
  localparam logic [31:0] FFR = `VPIC_FFR_ADDR;
  localparam logic [31:0] EOI = `VPIC_EOI_ADDR;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] irq_source = 32'hffffffff;
  logic [31:0] cpu_addr = 32'h0;
  logic [31:0] cpu_wdata = 32'h0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic irq_unmask = 1'b0;
  logic handler_done = 1'b0;
  logic [31:0] cpu_rdata;
  logic cpu_ready;
  logic [31:0] handler_addr;
  logic handler_valid;
  logic fast_pending;
  logic req_n;
  logic [31:0] rd;
  int n_fail = 0;
  int comparisons = 0;

  vpic_link_if i_vpic_link_if ();
  assign req_n = i_vpic_link_if.normal_irq_request_n;
  vpic_device i_vpic_device (.sys_clk(sys_clk), .reset_n(reset_n),
    .irq_source(irq_source), .link(i_vpic_link_if));
  vpic_core_end i_vpic_core_end (.sys_clk(sys_clk), .reset_n(reset_n),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready), .irq_unmask(irq_unmask),
    .handler_addr(handler_addr), .handler_valid(handler_valid),
    .handler_done(handler_done), .fast_pending(fast_pending), .link(i_vpic_link_if));
  vpic_link_monitor i_vpic_link_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_addr(i_vpic_link_if.bus_addr), .bus_wdata(i_vpic_link_if.bus_wdata),
    .bus_wr(i_vpic_link_if.bus_wr), .bus_rd(i_vpic_link_if.bus_rd),
    .bus_rdata(i_vpic_link_if.bus_rdata), .normal_irq_request_n(req_n),
    .fast_irq_request_n(i_vpic_link_if.fast_irq_request_n));

  always #2.5 sys_clk = ~sys_clk;

  task tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wt

  task src(input int n, input logic v);
    @(posedge sys_clk);
    irq_source[n] <= v;
  endtask : src

  // Extra edge lets the controller take the bus write before returning
  task cpu_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : cpu_write

  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    wt(1);
    rd = cpu_rdata;
    chk(rd, exp);
  endtask : rdchk

  task cfg(input int n, input logic [7:0] mode, input logic [31:0] vec);
    src(n, 1'b0);
    cpu_write(`VPIC_SMR_BASE + 32'(4 * n), {24'h0, mode});
    cpu_write(`VPIC_SVR_BASE + 32'(4 * n), vec);
  endtask : cfg

  task t_reset;
    wt(1);
    chk1(req_n, 1'b1);
    chk1(fast_pending, 1'b0);
    rdchk(CUR, 32'h0);
    rdchk(32'hfffff1f0, 32'h0);
  endtask : t_reset

  task t_tie;
    cfg(2, 8'h22, 32'h200);
    cfg(3, 8'h25, 32'h300);
    cfg(7, 8'h25, 32'h700);
    cpu_write(IEN, 32'h8c);
    src(2, 1'b1);
    wt(3);
    chk1(req_n, 1'b0);
    src(3, 1'b1);
    src(7, 1'b1);
    wt(3);
    rdchk(IVR, 32'h300);
    chk1(req_n, 1'b1);
    rdchk(CUR, 32'h1a3);
    chk1(req_n, 1'b1);
    src(3, 1'b0);
    cpu_write(EOI, 32'h0);
    wt(3);
    chk1(req_n, 1'b0);
    rdchk(IVR, 32'h700);
    src(7, 1'b0);
    cpu_write(EOI, 32'h0);
    rdchk(IVR, 32'h200);
    src(2, 1'b0);
    cpu_write(EOI, 32'h0);
  endtask : t_tie

  task t_nest;
    int i;
    for (i = 0; i < 8; i++)
      cfg(8 + i, 8'h60 | 8'(i), 32'h1000 + 32'(i));
    cpu_write(IEN, 32'hff00);
    for (i = 0; i < 8; i++)
    begin
      src(8 + i, 1'b1);
      wt(3);
      chk1(req_n, 1'b0);
      rdchk(IVR, 32'h1000 + 32'(i));
    end
    rdchk(CUR, 32'h8ef);
    rdchk(PEND, 32'h0);
    for (i = 7; i > 0; i--)
    begin
      cpu_write(EOI, 32'h0);
      rdchk(CUR, {20'h0, 4'(i), 3'(i - 1), 5'(7 + i)});
    end
    cpu_write(EOI, 32'h0);
    rdchk(CUR, 32'h0);
    chk1(req_n, 1'b1);
    @(posedge sys_clk);
    irq_source[15:8] <= 8'h0;
  endtask : t_nest

  task t_edge;
    cfg(16, 8'h64, 32'h1600);
    cfg(17, 8'h64, 32'h1700);
    cpu_write(IEN, 32'h30000);
    src(16, 1'b1);
    src(17, 1'b1);
    src(16, 1'b0);
    src(17, 1'b0);
    wt(3);
    rdchk(PEND, 32'h30000);
    rdchk(IVR, 32'h1600);
    rdchk(PEND, 32'h20000);
    cpu_write(EOI, 32'h0);
    wt(3);
    chk1(req_n, 1'b0);
    rdchk(IVR, 32'h1700);
    cpu_write(EOI, 32'h0);
    rdchk(PEND, 32'h0);
  endtask : t_edge

  task t_mask;
    cfg(20, 8'h67, 32'h2000);
    cfg(0, 8'h20, 32'h0);
    cpu_write(IEN, 32'h0);
    src(20, 1'b1);
    src(20, 1'b0);
    wt(3);
    chk1(req_n, 1'b1);
    rdchk(IVR, `VPIC_SPURIOUS_VEC);
    rdchk(CUR, 32'h0);
    cpu_write(FFR, 32'h100000);
    cpu_write(IEN, 32'h100000);
    wt(3);
    chk1(req_n, 1'b1);
    chk1(fast_pending, 1'b1);
    rdchk(IVR, `VPIC_SPURIOUS_VEC);
    rdchk(PEND, 32'h100000);
    cpu_write(FFR, 32'h0);
    cpu_write(IEN, 32'h1);
    src(0, 1'b1);
    wt(3);
    chk1(req_n, 1'b1);
    chk1(fast_pending, 1'b1);
    src(0, 1'b0);
    wt(3);
    chk1(fast_pending, 1'b0);
  endtask : t_mask

  // Negative edge and low level types, mode readback, fast vector
  task t_modes;
    cfg(22, 8'h41, 32'h2200);
    cfg(23, 8'h03, 32'h2300);
    src(22, 1'b1);
    src(22, 1'b0);
    cpu_write(IEN, 32'hc00000);
    rdchk(PEND, 32'hd00000);
    rdchk(IVR, 32'h2300);
    src(23, 1'b1);
    cpu_write(EOI, 32'h0);
    rdchk(IVR, 32'h2200);
    rdchk(PEND, 32'h100000);
    cpu_write(EOI, 32'h0);
    rdchk(`VPIC_SMR_BASE + 32'h58, 32'h41);
    cpu_write(`VPIC_SVR_BASE, 32'hf00);
    rdchk(`VPIC_FVR_ADDR, 32'hf00);
  endtask : t_modes

  task t_core;
    cfg(21, 8'h23, 32'h2100);
    cpu_write(IEN, 32'h200000);
    @(posedge sys_clk);
    irq_unmask <= 1'b1;
    irq_source[21] <= 1'b1;
    repeat (20)
    begin
      wt(1);
      if (handler_valid === 1'b1)
        break;
    end
    chk1(handler_valid, 1'b1);
    chk(handler_addr, 32'h2100);
    chk1(req_n, 1'b1);
    chk1(cpu_ready, 1'b0);
    @(posedge sys_clk);
    irq_source[21] <= 1'b0;
    irq_unmask <= 1'b0;
    // Dropped while the service is open
    cpu_write(IEN, 32'h0);
    @(posedge sys_clk);
    handler_done <= 1'b1;
    @(posedge sys_clk);
    handler_done <= 1'b0;
    repeat (10)
    begin
      wt(1);
      if (cpu_ready === 1'b1)
        break;
    end
    rdchk(CUR, 32'h0);
    chk1(cpu_ready, 1'b1);
    chk1(req_n, 1'b1);
    rdchk(IEN, 32'h200000);
  endtask : t_core

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish;
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_tie;
    t_nest;
    t_edge;
    t_mask;
    t_core;
    t_modes;
    tally_and_finish;
  end
endmodule : tb_vectored_priority_irq_controller
